// File: core/dcc_top.sv
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - status bit high when positive input exceeds negative, flipped by inversion; bits 7,6.
// - three-bit mode field in control bits 2:0 picks one of eight modes.
// - mode 011 uses pins 0,1 as negative inputs, pin 2 shared positive.
// - mode 010 feeds the internal reference to both positive inputs.
// - output status bits are read-only; writes leave them alone.
// - modes 110 and 001 route raw comparator outputs onto pins 3 and 4.
// - direction bits still gate driving of pins 3 and 4.
// - port read returns 0 for pins used as analog inputs, except pin 3 when the switch bit selects it in mode 001.
// - change flag, bit 6, sets when outputs differ from latched reference.
// - writing one to the change flag sets it; writing zero clears it only in a cycle with no mismatch.
// - interrupt reaches the processor only with all three enables set.
// - change flag sets regardless of interrupt enables.
// - a change coinciding with a control access is still flagged against the old reference.
// - any control register access latches outputs as the reference.
// - flag keeps re-setting while the mismatch persists.
// - reset returns control register to mode 000, comparators off.
// - mode 111 turns comparators off; active modes keep running in sleep.
// - waking from sleep leaves the control register unchanged.
module dcc_top
  import dcc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [ADR_W-1:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic STB_I,
  input wire logic CYC_I,
  output logic ACK_O,
  input wire logic CMP_ONE_RAW,
  input wire logic CMP_TWO_RAW,
  output logic CMP_ONE_EN,
  output logic CMP_TWO_EN,
  output dcc_sel_t CMP_ONE_POS_SEL,
  output dcc_sel_t CMP_ONE_NEG_SEL,
  output dcc_sel_t CMP_TWO_POS_SEL,
  output dcc_sel_t CMP_TWO_NEG_SEL,
  input wire logic [PIN_W-1:0] PA_IN,
  output logic [PIN_W-1:0] PA_OUT,
  output logic [PIN_W-1:0] PA_OE_N,
  output logic [3:0] PA_ANALOG,
  output logic IRQ,
  output logic WAKE_REQ
);

  dcc_mode_t comparator_mode_field;
  logic input_switch_sel;
  logic cmp_one_invert;
  logic cmp_two_invert;
  logic comparator_change_flag;
  logic comparator_irq_enable;
  logic peripheral_irq_enable;
  logic global_irq_enable;
  logic [PIN_W-1:0] dir_r;
  logic [PIN_W-1:0] latch_r;
  logic [1:0] ref_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic pin_out_en_r;
  logic [3:0] analog_r;
  logic irq_r;
  logic wake_r;

  dcc_sel_t one_pos_nxt;
  dcc_sel_t one_neg_nxt;
  dcc_sel_t two_pos_nxt;
  dcc_sel_t two_neg_nxt;
  logic one_on_nxt;
  logic two_on_nxt;
  logic [3:0] analog_nxt;
  logic pin_out_en_nxt;

  logic req;
  logic wr;
  logic [9:0] idx;
  logic hit_ctl;
  logic hit_flag;
  logic hit_ena;
  logic hit_irqc;
  logic hit_dir;
  logic hit_port;
  logic [7:0] rd_mux;
  logic cmp_one_out;
  logic cmp_two_out;
  logic [1:0] cmp_sync;
  logic mismatch;
  logic [PIN_W-1:0] port_rd;

  // ---- bus slave: one registered ack per request
  assign req = CYC_I & STB_I & ~ack_r;
  assign wr = req & WE_I & SEL_I[0];
  assign idx = ADR_I[ADR_W-1:2];
  always_comb begin
    hit_ctl = 1'b0;
    hit_flag = 1'b0;
    hit_ena = 1'b0;
    hit_irqc = 1'b0;
    hit_dir = 1'b0;
    hit_port = 1'b0;
    if (idx == CTL_IDX) begin
      hit_ctl = 1'b1;
    end else if (idx == FLAG_IDX) begin
      hit_flag = 1'b1;
    end else if (idx == ENA_IDX) begin
      hit_ena = 1'b1;
    end else if (idx == IRQC_IDX) begin
      hit_irqc = 1'b1;
    end else if (idx == DIR_IDX) begin
      hit_dir = 1'b1;
    end else if (idx == PORT_IDX) begin
      hit_port = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // ---- raw comparator path, inversion applied before pins and sync
  assign cmp_one_out = (CMP_ONE_RAW & CMP_ONE_EN) ^ cmp_one_invert;
  assign cmp_two_out = (CMP_TWO_RAW & CMP_TWO_EN) ^ cmp_two_invert;

  dcc_sync #(
    .WIDTH(2)
  ) u_sync (
    .sys_clk(SYS_CLK),
    .rst(RST),
    .async_in({cmp_two_out, cmp_one_out}),
    .sync_out(cmp_sync)
  );

  // analog inputs read as zero; pin 4 is never analog
  assign port_rd = PA_IN & ~{1'b0, analog_r};

  always_comb begin
    rd_mux = 8'h00;
    if (hit_ctl) begin
      // status bits come only from the synchroniser, never from a write
      rd_mux = {cmp_sync, cmp_two_invert, cmp_one_invert, input_switch_sel,
                comparator_mode_field};
    end else if (hit_flag) begin
      rd_mux[FLAG_CMP_BIT] = comparator_change_flag;
    end else if (hit_ena) begin
      rd_mux[ENA_CMP_BIT] = comparator_irq_enable;
    end else if (hit_irqc) begin
      rd_mux[IRQC_GLOBAL_BIT] = global_irq_enable;
      rd_mux[IRQC_PERIPH_BIT] = peripheral_irq_enable;
    end else if (hit_dir) begin
      rd_mux = {3'h0, dir_r};
    end else if (hit_port) begin
      rd_mux = {3'h0, port_rd};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      dat_r <= 32'h0000_0000;
    end else if (req && !WE_I) begin
      dat_r <= {24'h00_0000, rd_mux};
    end else begin
      dat_r <= 32'h0000_0000;
    end
  end

  // ---- control register; only writes and sync reset change it, sleep does not
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      comparator_mode_field <= MODE_RESET;
      input_switch_sel <= 1'b0;
      cmp_one_invert <= INV_RESET[0];
      cmp_two_invert <= INV_RESET[1];
    end else if (wr && hit_ctl) begin
      comparator_mode_field <= dcc_mode_t'(DAT_I[CTL_MODE_LSB +: 3]);
      input_switch_sel <= DAT_I[CTL_SWITCH_BIT];
      cmp_one_invert <= DAT_I[CTL_ONE_INV_BIT];
      cmp_two_invert <= DAT_I[CTL_TWO_INV_BIT];
    end
  end

  // ---- change detection: any control register access re-arms the reference
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ref_r <= 2'h0;
    end else if (req && hit_ctl) begin
      ref_r <= cmp_sync;
    end
  end

  // a change landing on the access edge is still flagged via the old reference
  assign mismatch = (cmp_sync != ref_r);

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      comparator_change_flag <= FLAG_RESET;
    end else if (mismatch) begin
      comparator_change_flag <= 1'b1;
    end else if (wr && hit_flag) begin
      comparator_change_flag <= DAT_I[FLAG_CMP_BIT];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      comparator_irq_enable <= ENA_RESET;
      peripheral_irq_enable <= ENA_RESET;
      global_irq_enable <= ENA_RESET;
    end else if (wr && hit_ena) begin
      comparator_irq_enable <= DAT_I[ENA_CMP_BIT];
    end else if (wr && hit_irqc) begin
      global_irq_enable <= DAT_I[IRQC_GLOBAL_BIT];
      peripheral_irq_enable <= DAT_I[IRQC_PERIPH_BIT];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      dir_r <= DIR_RESET;
      latch_r <= LATCH_RESET;
    end else if (wr && hit_dir) begin
      dir_r <= DAT_I[PIN_W-1:0];
    end else if (wr && hit_port) begin
      latch_r <= DAT_I[PIN_W-1:0];
    end
  end

  // ---- routing, registered onto the analog selects
  dcc_route u_route (
    .mode(comparator_mode_field),
    .input_switch_sel(input_switch_sel),
    .one_pos(one_pos_nxt),
    .one_neg(one_neg_nxt),
    .two_pos(two_pos_nxt),
    .two_neg(two_neg_nxt),
    .one_on(one_on_nxt),
    .two_on(two_on_nxt),
    .analog_mask(analog_nxt),
    .pin_out_en(pin_out_en_nxt)
  );

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      CMP_ONE_POS_SEL <= SEL_NONE;
      CMP_ONE_NEG_SEL <= SEL_NONE;
      CMP_TWO_POS_SEL <= SEL_NONE;
      CMP_TWO_NEG_SEL <= SEL_NONE;
      CMP_ONE_EN <= 1'b0;
      CMP_TWO_EN <= 1'b0;
      analog_r <= 4'hF;
      pin_out_en_r <= 1'b0;
    end else begin
      CMP_ONE_POS_SEL <= one_pos_nxt;
      CMP_ONE_NEG_SEL <= one_neg_nxt;
      CMP_TWO_POS_SEL <= two_pos_nxt;
      CMP_TWO_NEG_SEL <= two_neg_nxt;
      CMP_ONE_EN <= one_on_nxt;
      CMP_TWO_EN <= two_on_nxt;
      analog_r <= analog_nxt;
      pin_out_en_r <= pin_out_en_nxt;
    end
  end

  // ---- interrupt gating; flag and wake keep working in sleep
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      irq_r <= comparator_change_flag & comparator_irq_enable &
               peripheral_irq_enable & global_irq_enable;
      wake_r <= comparator_change_flag & comparator_irq_enable;
    end
  end

  // pins 3,4 carry the unsynchronised result, so they bypass any flop
  assign PA_OUT = {pin_out_en_r ? cmp_two_out : latch_r[4],
                   pin_out_en_r ? cmp_one_out : latch_r[3],
                   latch_r[2:0]};
  assign PA_OE_N = dir_r;
  assign PA_ANALOG = analog_r;
  assign ACK_O = ack_r;
  assign DAT_O = dat_r;
  assign IRQ = irq_r;
  assign WAKE_REQ = wake_r;

  // ---- checks
  a_flag_on_change: assert property (@(posedge SYS_CLK) disable iff (RST)
    mismatch |=> comparator_change_flag)
    else $error("change flag not set on mismatch");
  a_flag_no_enable: assert property (@(posedge SYS_CLK) disable iff (RST)
    (mismatch && !comparator_irq_enable && !global_irq_enable) |-> ##1 comparator_change_flag)
    else $error("change flag gated by enables");
  a_flag_clear_blocked: assert property (@(posedge SYS_CLK) disable iff (RST)
    (mismatch && wr && hit_flag && !DAT_I[FLAG_CMP_BIT]) |=> comparator_change_flag)
    else $error("flag cleared during mismatch");
  a_flag_soft_set: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr && hit_flag && DAT_I[FLAG_CMP_BIT]) |=> comparator_change_flag)
    else $error("software set of flag lost");
  a_ref_latch: assert property (@(posedge SYS_CLK) disable iff (RST)
    (req && hit_ctl) |=> (ref_r == $past(cmp_sync)))
    else $error("reference not latched on access");
  a_status_read: assert property (@(posedge SYS_CLK) disable iff (RST)
    (req && hit_ctl && !WE_I) |=> (ACK_O && DAT_O[7:6] == $past(cmp_sync)))
    else $error("status bits wrong on read");
  a_irq_gating: assert property (@(posedge SYS_CLK) disable iff (RST)
    ##1 (IRQ == $past(comparator_change_flag && comparator_irq_enable &&
                     peripheral_irq_enable && global_irq_enable)))
    else $error("interrupt gating wrong");
  a_vref_select: assert property (@(posedge SYS_CLK) disable iff (RST)
    (comparator_mode_field == MODE_VREF) |=>
      (CMP_ONE_POS_SEL == SEL_VREF && CMP_TWO_POS_SEL == SEL_VREF))
    else $error("reference not on positive inputs");
  a_mode_reset: assert property (@(posedge SYS_CLK)
    $past(RST) |-> (comparator_mode_field == MODE_RESET && !CMP_ONE_EN))
    else $error("mode not reset");
  a_ack_single: assert property (@(posedge SYS_CLK) disable iff (RST)
    ACK_O |=> !ACK_O)
    else $error("ack held beyond one cycle");

endmodule : dcc_top

// File: shared/dcc_pkg.sv
package dcc_pkg;

  localparam int DATA_W = 8;
  localparam int PIN_W = 5;
  localparam int ADR_W = 12;

  // register indices; byte address is four times the index
  localparam logic [9:0] CTL_IDX = 10'h01F;
  localparam logic [9:0] FLAG_IDX = 10'h00C;
  localparam logic [9:0] ENA_IDX = 10'h08C;
  localparam logic [9:0] IRQC_IDX = 10'h00B;
  localparam logic [9:0] DIR_IDX = 10'h085;
  localparam logic [9:0] PORT_IDX = 10'h005;

  // field positions
  localparam int CTL_TWO_RES_BIT = 7;
  localparam int CTL_ONE_RES_BIT = 6;
  localparam int CTL_TWO_INV_BIT = 5;
  localparam int CTL_ONE_INV_BIT = 4;
  localparam int CTL_SWITCH_BIT = 3;
  localparam int CTL_MODE_LSB = 0;
  localparam int FLAG_CMP_BIT = 6;
  localparam int ENA_CMP_BIT = 6;
  localparam int IRQC_GLOBAL_BIT = 7;
  localparam int IRQC_PERIPH_BIT = 6;

  // values after reset
  localparam logic [2:0] MODE_RESET_VAL = 3'h0;
  localparam logic [1:0] INV_RESET = 2'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic ENA_RESET = 1'b0;
  localparam logic [PIN_W-1:0] DIR_RESET = 5'h1F;
  localparam logic [PIN_W-1:0] LATCH_RESET = 5'h00;

  typedef enum logic [2:0] {
    MODE_RESET      = 3'h0,
    MODE_THREE_MUX  = 3'h1,
    MODE_VREF       = 3'h2,
    MODE_SHARED     = 3'h3,
    MODE_INDEP      = 3'h4,
    MODE_ONE_ONLY   = 3'h5,
    MODE_SHARED_OUT = 3'h6,
    MODE_OFF        = 3'h7
  } dcc_mode_t;

  // analog input selects; pin codes equal the pin number
  typedef enum logic [2:0] {
    SEL_PIN0 = 3'h0,
    SEL_PIN1 = 3'h1,
    SEL_PIN2 = 3'h2,
    SEL_PIN3 = 3'h3,
    SEL_VREF = 3'h4,
    SEL_NONE = 3'h7
  } dcc_sel_t;

endpackage : dcc_pkg

// File: core/dcc_sync.sv
`timescale 1ns/1ps
module dcc_sync
  import dcc_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one_r;
  logic [WIDTH-1:0] stage_two_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          stage_one_r[i] <= 1'b0;
          stage_two_r[i] <= 1'b0;
        end else begin
          stage_one_r[i] <= async_in[i];
          stage_two_r[i] <= stage_one_r[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage_two_r;

endmodule : dcc_sync

// File: core/dcc_route.sv
`timescale 1ns/1ps
module dcc_route
  import dcc_pkg::*;
(
  input wire dcc_mode_t mode,
  input wire logic input_switch_sel,
  output dcc_sel_t one_pos,
  output dcc_sel_t one_neg,
  output dcc_sel_t two_pos,
  output dcc_sel_t two_neg,
  output logic one_on,
  output logic two_on,
  output logic [3:0] analog_mask,
  output logic pin_out_en
);

  always_comb begin
    one_pos = SEL_NONE;
    one_neg = SEL_NONE;
    two_pos = SEL_NONE;
    two_neg = SEL_NONE;
    one_on = 1'b0;
    two_on = 1'b0;
    analog_mask = 4'hF;
    pin_out_en = 1'b0;
    case (mode)
      MODE_RESET: begin
        analog_mask = 4'hF;
      end
      MODE_THREE_MUX: begin
        one_neg = input_switch_sel ? SEL_PIN3 : SEL_PIN0;
        one_pos = SEL_PIN2;
        two_neg = SEL_PIN1;
        two_pos = SEL_PIN2;
        one_on = 1'b1;
        two_on = 1'b1;
        analog_mask = 4'h7;
        pin_out_en = 1'b1;
      end
      MODE_VREF: begin
        one_pos = SEL_VREF;
        two_pos = SEL_VREF;
        one_neg = input_switch_sel ? SEL_PIN3 : SEL_PIN0;
        two_neg = input_switch_sel ? SEL_PIN2 : SEL_PIN1;
        one_on = 1'b1;
        two_on = 1'b1;
        analog_mask = 4'hF;
      end
      MODE_SHARED: begin
        one_neg = SEL_PIN0;
        two_neg = SEL_PIN1;
        one_pos = SEL_PIN2;
        two_pos = SEL_PIN2;
        one_on = 1'b1;
        two_on = 1'b1;
        analog_mask = 4'h7;
      end
      MODE_INDEP: begin
        one_neg = SEL_PIN0;
        one_pos = SEL_PIN3;
        two_neg = SEL_PIN1;
        two_pos = SEL_PIN2;
        one_on = 1'b1;
        two_on = 1'b1;
        analog_mask = 4'hF;
      end
      MODE_ONE_ONLY: begin
        two_neg = SEL_PIN1;
        two_pos = SEL_PIN2;
        two_on = 1'b1;
        analog_mask = 4'h6;
      end
      MODE_SHARED_OUT: begin
        one_neg = SEL_PIN0;
        two_neg = SEL_PIN1;
        one_pos = SEL_PIN2;
        two_pos = SEL_PIN2;
        one_on = 1'b1;
        two_on = 1'b1;
        analog_mask = 4'h7;
        pin_out_en = 1'b1;
      end
      MODE_OFF: begin
        analog_mask = 4'h0;
      end
      default: begin
        analog_mask = 4'hF;
      end
    endcase
  end

endmodule : dcc_route

// File: testbench/dual_comparator_control_bench.sv
`timescale 1ns/1ps
module dual_comparator_control_bench;
  import dcc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0] dat_w = '0;
  logic [31:0] dat_r;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic stb = 1'b0;
  logic cyc = 1'b0;
  logic ack;
  logic raw_one = 1'b0;
  logic raw_two = 1'b0;
  logic en_one;
  logic en_two;
  dcc_sel_t one_pos;
  dcc_sel_t one_neg;
  dcc_sel_t two_pos;
  dcc_sel_t two_neg;
  logic [PIN_W-1:0] pa_in = 5'h1F;
  logic [PIN_W-1:0] pa_out;
  logic [PIN_W-1:0] pa_oe_n;
  logic [3:0] pa_analog;
  logic irq;
  logic wake;
  logic [31:0] q;
  logic [1:0] shadow = 2'h0;
  int errors = 0;
  int tests_run = 0;

  always #2.5 sys_clk = ~sys_clk;

  dcc_top uut (
    .SYS_CLK(sys_clk), .RST(rst), .ADR_I(adr), .DAT_I(dat_w), .DAT_O(dat_r), .WE_I(we),
    .SEL_I(sel), .STB_I(stb), .CYC_I(cyc), .ACK_O(ack), .CMP_ONE_RAW(raw_one),
    .CMP_TWO_RAW(raw_two), .CMP_ONE_EN(en_one), .CMP_TWO_EN(en_two),
    .CMP_ONE_POS_SEL(one_pos), .CMP_ONE_NEG_SEL(one_neg), .CMP_TWO_POS_SEL(two_pos),
    .CMP_TWO_NEG_SEL(two_neg), .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE_N(pa_oe_n),
    .PA_ANALOG(pa_analog), .IRQ(irq), .WAKE_REQ(wake)
  );

  task automatic conclude();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // values read right after the edge are the pre-edge ones, as the master samples them
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] r);
    int i;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat_w <= {24'h00_0000, d};
    sel <= s;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (ack === 1'b1) break;
    end
    r = dat_r;
    if (i == 20) begin
      errors++;
      $display("CHECK FAILED bus ack expected 1 seen 0");
      conclude();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1, q);
  endtask : wr

  task automatic rdc(input string name, input logic [9:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00, 4'h0, q);
    chk(name, q, exp);
  endtask : rdc

  task automatic setraw(input logic a, input logic b);
    @(posedge sys_clk);
    raw_one <= a;
    raw_two <= b;
  endtask : setraw

  task automatic chkmode(input logic [7:0] ctl, input dcc_sel_t op, input dcc_sel_t on,
                         input dcc_sel_t tp, input dcc_sel_t tn);
    wr(CTL_IDX, ctl);
    tick(2);
    chk("one_pos", 32'(one_pos), 32'(op));
    chk("one_neg", 32'(one_neg), 32'(on));
    chk("two_pos", 32'(two_pos), 32'(tp));
    chk("two_neg", 32'(two_neg), 32'(tn));
  endtask : chkmode

  initial begin
    tick(10);
    rst <= 1'b0;
    tick(2);
    rdc("ctl reset", CTL_IDX, 32'h0000_0000);
    chk("analog reset", 32'(pa_analog), 32'h0000_000F);
    chk("en reset", 32'({en_one, en_two}), 32'h0000_0000);
    chk("oe reset", 32'(pa_oe_n), 32'h0000_001F);
    rdc("port mode0", PORT_IDX, 32'h0000_0010);
    rdc("dir reset", DIR_IDX, 32'h0000_001F);
    rdc("unmapped", 10'h3FF, 32'h0000_0000);
    // comparator 1 idles in modes 000, 101, 111; comparator 2 in 000, 111
    for (int m = 0; m < 8; m++) begin
      wr(CTL_IDX, 8'(m));
      tick(2);
      chk("en one", 32'(en_one), 32'(!(m == 0 || m == 5 || m == 7)));
      chk("en two", 32'(en_two), 32'(!(m == 0 || m == 7)));
    end
    chk("analog off", 32'(pa_analog), 32'h0000_0000);
    rdc("port off", PORT_IDX, 32'h0000_001F);
    chkmode(8'h03, SEL_PIN2, SEL_PIN0, SEL_PIN2, SEL_PIN1);
    chkmode(8'h02, SEL_VREF, SEL_PIN0, SEL_VREF, SEL_PIN1);
    chkmode(8'h0A, SEL_VREF, SEL_PIN3, SEL_VREF, SEL_PIN2);
    chkmode(8'h01, SEL_PIN2, SEL_PIN0, SEL_PIN2, SEL_PIN1);
    chkmode(8'h09, SEL_PIN2, SEL_PIN3, SEL_PIN2, SEL_PIN1);
    wr(CTL_IDX, 8'hC3);
    tick(3);
    rdc("ctl ro bits", CTL_IDX, 32'h0000_0003);
    chk("analog 011", 32'(pa_analog), 32'h0000_0007);
    rdc("port 011", PORT_IDX, 32'h0000_0018);
    bus(1'b1, DIR_IDX, 8'h00, 4'h0, q);
    rdc("dir no sel", DIR_IDX, 32'h0000_001F);
    wr(DIR_IDX, 8'h07);
    tick(2);
    chk("oe dir", 32'(pa_oe_n), 32'h0000_0007);
    wr(FLAG_IDX, 8'h00);
    rdc("flag clear", FLAG_IDX, 32'h0000_0000);
    setraw(1'b1, 1'b0);
    tick(6);
    rdc("flag change", FLAG_IDX, 32'h0000_0040);
    chk("irq masked", 32'(irq), 32'h0000_0000);
    wr(FLAG_IDX, 8'h00);
    rdc("flag sticky", FLAG_IDX, 32'h0000_0040);
    rdc("ctl one high", CTL_IDX, 32'h0000_0043);
    wr(FLAG_IDX, 8'h00);
    rdc("flag cleared", FLAG_IDX, 32'h0000_0000);
    wr(CTL_IDX, 8'h13);
    tick(4);
    rdc("ctl inverted", CTL_IDX, 32'h0000_0013);
    shadow = q[7:6];
    setraw(1'b1, 1'b1);
    tick(4);
    rdc("ctl two high", CTL_IDX, 32'h0000_0093);
    chk("changed bits", 32'(q[7:6] ^ shadow), 32'h0000_0002);
    // pins 3/4 follow the raw comparator outputs in modes 110 and 001
    setraw(1'b1, 1'b0);
    wr(PORT_IDX, 8'h00);
    wr(CTL_IDX, 8'h06);
    tick(2);
    chk("pins 110", 32'(pa_out[4:3]), 32'h0000_0001);
    wr(CTL_IDX, 8'h26);
    tick(2);
    chk("pins 110 inv", 32'(pa_out[4:3]), 32'h0000_0003);
    wr(CTL_IDX, 8'h01);
    tick(2);
    chk("pins 001", 32'(pa_out[4:3]), 32'h0000_0001);
    wr(PORT_IDX, 8'h18);
    wr(CTL_IDX, 8'h03);
    tick(3);
    chk("pins latch", 32'(pa_out), 32'h0000_0018);
    chk("oe kept", 32'(pa_oe_n), 32'h0000_0007);
    bus(1'b0, CTL_IDX, 8'h00, 4'h0, q);
    wr(FLAG_IDX, 8'h00);
    rdc("flag quiet", FLAG_IDX, 32'h0000_0000);
    wr(FLAG_IDX, 8'h40);
    rdc("flag soft set", FLAG_IDX, 32'h0000_0040);
    for (int k = 0; k < 8; k++) begin
      wr(ENA_IDX, {1'b0, k[0], 6'h00});
      wr(IRQC_IDX, {k[2], k[1], 6'h00});
      tick(2);
      chk("irq gate", 32'(irq), 32'(k == 7));
      chk("wake", 32'(wake), 32'(k[0]));
    end
    rdc("ctl after wake", CTL_IDX, 32'h0000_0043);
    wr(ENA_IDX, 8'h00);
    wr(IRQC_IDX, 8'h00);
    wr(FLAG_IDX, 8'h00);
    rdc("flag zero", FLAG_IDX, 32'h0000_0000);
    wr(CTL_IDX, 8'h3B);
    tick(4);
    chk("irq mode change", 32'(irq), 32'h0000_0000);
    @(posedge sys_clk);
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    tick(2);
    rdc("ctl rereset", CTL_IDX, 32'h0000_0000);
    chk("analog rereset", 32'(pa_analog), 32'h0000_000F);
    conclude();
  end
endmodule : dual_comparator_control_bench
